/* rtl/cpu_bitops_pkg.sv */
package cpu_bitops_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PC = 8'h08;
    localparam logic [7:0] ADDR_SEL = 8'h0C;
    localparam logic [7:0] ADDR_REG = 8'h10;
    localparam logic [7:0] ADDR_IO = 8'h14;
    localparam logic [7:0] ADDR_MEM = 8'h18;

    // Flag positions inside the flags register
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Field positions of the select and status words
    localparam int SEL_REG_LSB = 0;
    localparam int SEL_IO_LSB = 8;
    localparam int SEL_MEM_LSB = 16;
    localparam int STATUS_BUSY = 8;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;

    // Pointer pairs: low byte index, high byte is the next one
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;

    // Operation codes
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_BR_NO_OVF = 5'h01;
    localparam logic [4:0] OP_BR_IRQ_ON = 5'h02;
    localparam logic [4:0] OP_BR_IRQ_OFF = 5'h03;
    localparam logic [4:0] OP_IO_SET = 5'h04;
    localparam logic [4:0] OP_IO_CLR = 5'h05;
    localparam logic [4:0] OP_SHL = 5'h06;
    localparam logic [4:0] OP_SHR = 5'h07;
    localparam logic [4:0] OP_ROL = 5'h08;
    localparam logic [4:0] OP_ROR = 5'h09;
    localparam logic [4:0] OP_TSTORE = 5'h0A;
    localparam logic [4:0] OP_TLOAD = 5'h0B;
    localparam logic [4:0] OP_FLAG_SET = 5'h0C;
    localparam logic [4:0] OP_FLAG_CLR = 5'h0D;
    localparam logic [4:0] OP_LD = 5'h0E;
    localparam logic [4:0] OP_LD_INC = 5'h0F;
    localparam logic [4:0] OP_LD_DEC = 5'h10;
    localparam logic [4:0] OP_LDD = 5'h11;

    // Command word as written to the command register
    typedef struct packed {
        logic [4:0] spare;
        logic [1:0] ptr;
        logic [4:0] io;
        logic [6:0] k;
        logic [2:0] bitn;
        logic [4:0] rd;
        logic [4:0] op;
    } cmd_t;

    typedef enum {ST_IDLE, ST_EXEC, ST_FIN} exec_state_t;

endpackage : cpu_bitops_pkg

/* rtl/cpu_bitops_loads_exec.sv */
// Function
// - Branch if no overflow: PC+k+1, 1/2 cycles
// - Branches on global interrupt flag, 1/2 cycles
// - I/O bit set/clear, two cycles, no flags
// - Left shift zero fill, flags Z C N V S
// - Right shift zero fill, flags Z C N V S
// - Rotate left through carry, one cycle
// - Rotate right through carry, one cycle
// - Register bit copied into T flag
// - T flag copied into register bit
// - Flag set/clear touches only named flag
// - Load then pointer plus one, two cycles
// - Pointer minus one then load, two cycles
// - Load at Y/Z plus displacement, pointer kept
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module cpu_bitops_loads_exec
    import cpu_bitops_pkg::*;
#(
    parameter int unsigned MEM_AW = 8
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // AHB-Lite slave request
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    // AHB-Lite slave answer
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O
);

    logic [7:0] gpr [32];
    logic [7:0] io_reg [32];
    logic [7:0] dmem [2**MEM_AW];

    logic [7:0] flags;
    logic [15:0] pc;
    logic [31:0] sel;
    cmd_t cmd;
    exec_state_t state;
    logic [15:0] ld_addr_q;

    logic pend;
    logic pend_write;
    logic [7:0] pend_addr;

    // Bus decode
    wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire busy = (state != ST_IDLE);
    wire data_phase = pend & ~HREADYOUT_O;
    // Writes wait while an instruction runs, so bus and core never collide
    wire bus_wr = data_phase & pend_write & ~busy;
    wire bus_rd = data_phase & ~pend_write;
    wire wr_cmd = bus_wr & (pend_addr == ADDR_CMD);
    wire wr_status = bus_wr & (pend_addr == ADDR_STATUS);
    wire wr_pc = bus_wr & (pend_addr == ADDR_PC);
    wire wr_sel = bus_wr & (pend_addr == ADDR_SEL);
    wire wr_reg = bus_wr & (pend_addr == ADDR_REG);
    wire wr_io = bus_wr & (pend_addr == ADDR_IO);
    wire wr_mem = bus_wr & (pend_addr == ADDR_MEM);

    wire [4:0] sel_reg = sel[SEL_REG_LSB +: 5];
    wire [4:0] sel_io = sel[SEL_IO_LSB +: 5];
    wire [MEM_AW-1:0] sel_mem = sel[SEL_MEM_LSB +: MEM_AW];

    wire [31:0] next_rdata =
        (pend_addr == ADDR_CMD) ? cmd :
        (pend_addr == ADDR_STATUS) ? {23'h00_0000, busy, flags} :
        (pend_addr == ADDR_PC) ? {16'h0000, pc} :
        (pend_addr == ADDR_SEL) ? sel :
        (pend_addr == ADDR_REG) ? {24'h00_0000, gpr[sel_reg]} :
        (pend_addr == ADDR_IO) ? {24'h00_0000, io_reg[sel_io]} :
        (pend_addr == ADDR_MEM) ? {24'h00_0000, dmem[sel_mem]} :
        32'h0000_0000;

    // Operand and result paths
    wire [7:0] rd_val = gpr[cmd.rd];
    wire op_shl = (cmd.op == OP_SHL);
    wire op_shr = (cmd.op == OP_SHR);
    wire op_rol = (cmd.op == OP_ROL);
    wire op_ror = (cmd.op == OP_ROR);
    wire op_ld_inc = (cmd.op == OP_LD_INC);
    wire op_ld_dec = (cmd.op == OP_LD_DEC);
    wire op_ldd = (cmd.op == OP_LDD);
    wire old_c = flags[FLAG_C];

    wire [8:0] sh_all =
        op_shl ? {rd_val, 1'b0} :
        op_rol ? {rd_val, old_c} :
        op_shr ? {rd_val[0], 1'b0, rd_val[7:1]} :
        {rd_val[0], old_c, rd_val[7:1]};
    wire sh_c = sh_all[8];
    wire [7:0] sh_res = sh_all[7:0];
    wire sh_n = sh_res[7];
    wire sh_v = sh_n ^ sh_c;
    wire sh_z = (sh_res == 8'h00);
    wire [7:0] sh_flags = {flags[7:5], sh_n ^ sh_v, sh_v, sh_n, sh_z, sh_c};

    wire [7:0] flag_mask = 8'h01 << cmd.bitn;

    // Flags are read straight from the register, so no forwarding stall
    wire br_take =
        ((cmd.op == OP_BR_NO_OVF) & ~flags[FLAG_V]) |
        ((cmd.op == OP_BR_IRQ_ON) & flags[FLAG_I]) |
        ((cmd.op == OP_BR_IRQ_OFF) & ~flags[FLAG_I]);
    wire is_branch = (cmd.op == OP_BR_NO_OVF) |
        (cmd.op == OP_BR_IRQ_ON) | (cmd.op == OP_BR_IRQ_OFF);
    wire [15:0] pc_inc = pc + 16'h0001;
    wire [15:0] br_target = pc_inc + {{9{cmd.k[6]}}, cmd.k};

    wire is_load = (cmd.op == OP_LD) | op_ld_inc | op_ld_dec | op_ldd;
    wire is_two = is_load | (cmd.op == OP_IO_SET) | (cmd.op == OP_IO_CLR);
    wire [4:0] ptr_lo = (cmd.ptr == PTR_X) ? PTR_X_LO :
        (cmd.ptr == PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
    wire [4:0] ptr_hi = ptr_lo | 5'h01;
    wire [15:0] ptr_val = {gpr[ptr_hi], gpr[ptr_lo]};
    wire [15:0] ptr_dec = ptr_val - 16'h0001;
    wire [15:0] ptr_inc = ptr_val + 16'h0001;
    wire [15:0] ld_addr =
        op_ld_dec ? ptr_dec :
        op_ldd ? ptr_val + {10'h000, cmd.k[5:0]} :
        ptr_val;
    wire [15:0] ptr_new = op_ld_inc ? ptr_inc :
        op_ld_dec ? ptr_dec : ptr_val;
    wire [7:0] ld_data = dmem[ld_addr_q[MEM_AW-1:0]];

    // Bus slave: every transfer gets one wait state, writes more if busy
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_addr <= 8'h00;
            HREADYOUT_O <= 1'b1;
            HRDATA_O <= 32'h0000_0000;
            HRESP_O <= 1'b0;
        end else begin
            if (addr_ok) begin
                pend <= 1'b1;
                pend_write <= HWRITE_I;
                pend_addr <= {HADDR_I[7:2], 2'b00};
                HREADYOUT_O <= 1'b0;
            end else if (bus_wr | bus_rd) begin
                pend <= 1'b0;
                HREADYOUT_O <= 1'b1;
            end
            if (bus_rd) begin
                HRDATA_O <= next_rdata;
            end
            HRESP_O <= 1'b0;
        end
    end

    // Data memory holds no reset; only software fills it
    always_ff @(posedge CLK_I) begin
        if (wr_mem) begin
            dmem[sel_mem] <= HWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state <= ST_IDLE;
            cmd <= '0;
            flags <= FLAGS_RESET;
            pc <= PC_RESET;
            sel <= SEL_RESET;
            ld_addr_q <= 16'h0000;
            for (int i = 0; i < 32; i++) begin
                gpr[i] <= 8'h00;
                io_reg[i] <= 8'h00;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_cmd) begin
                        cmd <= cmd_t'(HWDATA_I);
                        state <= ST_EXEC;
                    end
                    if (wr_status) begin
                        flags <= HWDATA_I[7:0];
                    end
                    if (wr_pc) begin
                        pc <= HWDATA_I[15:0];
                    end
                    if (wr_sel) begin
                        sel <= HWDATA_I;
                    end
                    if (wr_reg) begin
                        gpr[sel_reg] <= HWDATA_I[7:0];
                    end
                    if (wr_io) begin
                        io_reg[sel_io] <= HWDATA_I[7:0];
                    end
                end
                ST_EXEC: begin
                    state <= ST_IDLE;
                    pc <= pc_inc;
                    if (is_two || (is_branch && br_take)) begin
                        state <= ST_FIN;
                        pc <= pc;
                    end
                    ld_addr_q <= ld_addr;
                    if (is_load) begin
                        {gpr[ptr_hi], gpr[ptr_lo]} <= ptr_new;
                    end
                    case (cmd.op)
                        OP_SHL, OP_SHR, OP_ROL, OP_ROR: begin
                            gpr[cmd.rd] <= sh_res;
                            flags <= sh_flags;
                        end
                        OP_TSTORE: begin
                            flags[FLAG_T] <= rd_val[cmd.bitn];
                        end
                        OP_TLOAD: begin
                            gpr[cmd.rd][cmd.bitn] <= flags[FLAG_T];
                        end
                        OP_FLAG_SET: begin
                            flags <= flags | flag_mask;
                        end
                        OP_FLAG_CLR: begin
                            flags <= flags & ~flag_mask;
                        end
                        default: begin
                        end
                    endcase
                end
                ST_FIN: begin
                    state <= ST_IDLE;
                    pc <= is_branch ? br_target : pc_inc;
                    if (cmd.op == OP_IO_SET) begin
                        io_reg[cmd.io][cmd.bitn] <= 1'b1;
                    end
                    if (cmd.op == OP_IO_CLR) begin
                        io_reg[cmd.io][cmd.bitn] <= 1'b0;
                    end
                    if (is_load) begin
                        gpr[cmd.rd] <= ld_data;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : cpu_bitops_loads_exec

`default_nettype wire

/* tb/cpu_bitops_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bitops_props (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Bus signals
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O
);
    logic pend;
    wire logic take = HSEL_I & HTRANS_I[1] & HREADY_I;
    // Open from address phase until the answer
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I)
            pend <= 1'b0;
        else if (take | HREADYOUT_O)
            pend <= take;
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_wait;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence
    a_resp_okay: assert property (!HRESP_O)
        else $error("response not okay");
    a_read_wait: assert property (take && !HWRITE_I |=> s_wait)
        else $error("read answer not after one wait");
    a_take_low: assert property (take |=> !HREADYOUT_O)
        else $error("ready high after address phase");
    a_write_bound: assert property (take && HWRITE_I |=> ##[1:3] HREADYOUT_O)
        else $error("write stalled too long");
    a_ready_hold: assert property (HREADYOUT_O && !take |=> HREADYOUT_O)
        else $error("ready dropped while idle");
    a_low_pend: assert property (!HREADYOUT_O |-> pend)
        else $error("wait state with no transfer");
    a_data_hold: assert property ($changed(HRDATA_O) |-> pend && HREADYOUT_O)
        else $error("read data changed outside answer");
    a_upper_zero: assert property (HREADYOUT_O |-> HRDATA_O[31:27] == 5'h00)
        else $error("read data upper bits set");
endmodule : cpu_bitops_props
bind cpu_bitops_loads_exec cpu_bitops_props i_props (.CLK_I, .RST_B_I,
    .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O,
    .HRESP_O);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpu_bitops_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] q;
    logic [7:0] v, r;
    logic [4:0] op;
    logic c;
    wire logic [31:0] hrdata;
    wire logic hready, hresp;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    cpu_bitops_loads_exec i_cpu_bitops_loads_exec (
        .CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp));
    task automatic summarize;
        $display("Checked %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize
    // Run needs under a thousand cycles; this only catches a hang
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    // Each phase held until hready is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : bus
    task automatic rc(input string n, input logic [7:0] a,
        input logic [7:0] e);
        bus(1'b0, a, 32'h0000_0000);
        checked++;
        if (q !== {24'h0, e}) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, q);
        end
    endtask : rc
    task automatic ex(input logic [4:0] o, d, input logic [2:0] b = 3'h0,
        input logic [1:0] p = 2'h0, input logic [6:0] k = 7'h00,
        input logic [4:0] io = 5'h00);
        bus(1'b1, ADDR_CMD, cmd_t'{5'h00, p, io, k, b, d, o});
    endtask : ex
    task automatic sel(input logic [4:0] g, io, input logic [7:0] m);
        bus(1'b1, ADDR_SEL, {8'h0, m, 3'h0, io, 3'h0, g});
    endtask : sel
    task automatic setr(input logic [4:0] g, input logic [7:0] d);
        sel(g, 5'h00, 8'h00);
        bus(1'b1, ADDR_REG, {24'h0, d});
    endtask : setr
    task automatic gr(input string n, input logic [4:0] g,
        input logic [7:0] e);
        sel(g, 5'h00, 8'h00);
        rc(n, ADDR_REG, e);
    endtask : gr
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        hsel <= 1'b1;
        rc("pc", ADDR_PC, 8'h00);
        rc("unmapped", 8'h1C, 8'h00);
        // Old carry is 1, so rotates and shifts differ in the fill bit
        for (int i = 0; i < 8; i++) begin
            op = OP_SHL + 5'(i / 2);
            v = (i % 2) ? 8'h01 : 8'h80;
            setr(5'h05, v);
            bus(1'b1, ADDR_STATUS, 32'h0000_0021);
            ex(op, 5'h05);
            c = (op == OP_SHL || op == OP_ROL) ? v[7] : v[0];
            r = (op == OP_SHL || op == OP_ROL) ? {v[6:0], op == OP_ROL}
                : {op == OP_ROR, v[7:1]};
            gr("shift result", 5'h05, r);
            v = {3'h1, c, r[7] ^ c, r[7], r == 8'h00, c};
            rc("shift flags", ADDR_STATUS, v);
        end
        $display("Test shifts done");
        // Flag written by the instruction just before the branch
        for (int i = 0; i < 6; i++) begin
            op = OP_BR_NO_OVF + 5'(i % 3);
            c = i > 2;
            r = (op == OP_BR_NO_OVF) ? 8'(FLAG_V) : 8'(FLAG_I);
            bus(1'b1, ADDR_PC, 32'h0000_0040);
            ex(c ? OP_FLAG_SET : OP_FLAG_CLR, 5'h00, r[2:0]);
            ex(op, 5'h00, 3'h0, 2'h0, 7'h7D);
            v = (c ^ (op != OP_BR_IRQ_ON)) ? 8'h3F : 8'h42;
            rc("branch pc", ADDR_PC, v);
        end
        $display("Test branches done");
        for (int i = 0; i < 16; i++) begin
            c = i > 7;
            v = 8'h01 << (i % 8);
            bus(1'b1, ADDR_STATUS, c ? 32'h0000_00FF : 32'h0000_0000);
            ex(c ? OP_FLAG_CLR : OP_FLAG_SET, 5'h00, 3'(i % 8));
            rc("flag", ADDR_STATUS, c ? ~v : v);
        end
        $display("Test flags done");
        bus(1'b1, ADDR_STATUS, 32'h0000_0000);
        setr(5'h03, 8'h20);
        ex(OP_TSTORE, 5'h03, 3'h5);
        rc("t store", ADDR_STATUS, 8'h40);
        setr(5'h04, 8'h00);
        ex(OP_TLOAD, 5'h04, 3'h2);
        gr("t load", 5'h04, 8'h04);
        rc("t load flags", ADDR_STATUS, 8'h40);
        bus(1'b1, ADDR_STATUS, 32'h0000_000F);
        sel(5'h00, 5'h07, 8'h00);
        bus(1'b1, ADDR_IO, 32'h0000_00A5);
        // Second command lands only after the first has finished
        ex(OP_IO_SET, 5'h00, 3'h1, 2'h0, 7'h00, 5'h07);
        ex(OP_IO_CLR, 5'h00, 3'h7, 2'h0, 7'h00, 5'h07);
        rc("io bits", ADDR_IO, 8'h27);
        rc("io flags", ADDR_STATUS, 8'h0F);
        $display("Test bits done");
        setr(5'h1A, 8'h10);
        setr(5'h1C, 8'h20);
        sel(5'h00, 5'h00, 8'h10);
        bus(1'b1, ADDR_MEM, 32'h0000_0011);
        sel(5'h00, 5'h00, 8'h11);
        bus(1'b1, ADDR_MEM, 32'h0000_0066);
        sel(5'h00, 5'h00, 8'h25);
        bus(1'b1, ADDR_MEM, 32'h0000_0055);
        ex(OP_LD_INC, 5'h01, 3'h0, PTR_X);
        gr("inc data", 5'h01, 8'h11);
        gr("inc ptr", 5'h1A, 8'h11);
        ex(OP_LD_DEC, 5'h02, 3'h0, PTR_X);
        gr("dec data", 5'h02, 8'h11);
        gr("dec ptr", 5'h1A, 8'h10);
        ex(OP_LDD, 5'h03, 3'h0, PTR_Y, 7'h05);
        gr("disp data", 5'h03, 8'h55);
        gr("disp ptr", 5'h1C, 8'h20);
        rc("load flags", ADDR_STATUS, 8'h0F);
        $display("Test loads done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
